// [ppom_pkg.sv]
// Package of constants and carrier types for the port pin override mux
package ppom_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int          PPOM_PINS      = 8;
	localparam int          PPOM_AW        = 8;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0]  PPOM_OFS_LATCH = 8'h00;
	localparam logic [7:0]  PPOM_OFS_DIR   = 8'h04;
	localparam logic [7:0]  PPOM_OFS_PIN   = 8'h08;
	localparam logic [7:0]  PPOM_OFS_CTRL  = 8'h0C;
	localparam logic [7:0]  PPOM_OFS_PCMSK = 8'h10;
	localparam logic [7:0]  PPOM_OFS_STAT  = 8'h14;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int          PPOM_CTRL_PULLUP_OFF  = 0;
	localparam int          PPOM_CTRL_ASYNC_SEL   = 1;
	localparam int          PPOM_CTRL_EXT_CLK_SEL = 2;
	localparam int          PPOM_CTRL_INTRC = 3;
	localparam int          PPOM_CTRL_EXTCK = 4;
	localparam int          PPOM_CTRL_PCIE  = 5;
	localparam int          PPOM_CTRL_W     = 6;

	// ------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------
	localparam int          PPOM_STAT_PB6CLK = 0;
	localparam int          PPOM_STAT_PB7CLK = 1;
	localparam int          PPOM_STAT_DRV    = 8;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  PPOM_RST_LATCH = 8'h00;
	localparam logic [7:0]  PPOM_RST_DIR   = 8'h00;
	localparam logic [7:0]  PPOM_RST_PCMSK = 8'h00;
	localparam logic [5:0]  PPOM_RST_CTRL  = 6'h08;

	// ------------------------------------------------------------
	// AHB-Lite encodings
	// ------------------------------------------------------------
	localparam logic [1:0]  PPOM_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  PPOM_HTRANS_SEQ    = 2'h3;
	localparam logic        PPOM_HRESP_OKAY    = 1'b0;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic pullup_ovr_en;
		logic pullup_ovr_val;
		logic dir_ovr_en;
		logic dir_ovr_val;
		logic value_ovr_en;
		logic value_ovr_val;
		logic toggle_ovr_en;
		logic input_en_ovr_en;
		logic input_en_ovr_val;
	} ppom_ovr_t;

	typedef struct packed {
		logic spi_en;
		logic spi_master;
		logic sck_out;
		logic spi_slave_out;
		logic spi_master_out;
		logic t2_cmp_a_en;
		logic timer2_cmp_a_out;
		logic t1_cmp_b_en;
		logic timer1_cmp_b_out;
		logic t1_cmp_a_en;
		logic timer1_cmp_a_out;
		logic clk_out_en;
		logic divided_clk_out;
	} ppom_periph_t;

	typedef struct packed {
		logic pullup_en;
		logic drv_en;
		logic drv_val;
		logic analog_sel;
	} ppom_pad_t;

endpackage

// [ppom_pin_cell.sv]
// One port pin: override multiplexing between register state, pad and alternate function
`timescale 1ns/10ps
module ppom_pin_cell
	import ppom_pkg::*;
(
	input  wire ppom_ovr_t ovr,
	input  wire logic      pin_direction_bit,
	input  wire logic      pin_out_latch_bit,
	input  wire logic      global_pullup_off,
	input  wire logic      sleep_clamp,
	input  wire logic      analog_req,
	input  wire logic      pad_in,
	output ppom_pad_t      pad,
	output logic           alt_func_input
);

	logic input_en;

	always_comb
	begin
		pad.analog_sel = analog_req;
		if (ovr.pullup_ovr_en)
		begin
			pad.pullup_en = ovr.pullup_ovr_val;
		end
		else
		begin
			pad.pullup_en = ({pin_direction_bit, pin_out_latch_bit, global_pullup_off}
				== 3'b010);
		end
		if (ovr.dir_ovr_en)
		begin
			pad.drv_en = ovr.dir_ovr_val;
		end
		else
		begin
			pad.drv_en = pin_direction_bit;
		end
		if (!pad.drv_en)
		begin
			pad.drv_val = 1'b0;
		end
		else if (ovr.value_ovr_en)
		begin
			pad.drv_val = ovr.value_ovr_val;
		end
		else
		begin
			pad.drv_val = pin_out_latch_bit;
		end
		if (ovr.input_en_ovr_en)
		begin
			input_en = ovr.input_en_ovr_val;
		end
		else
		begin
			input_en = !sleep_clamp;
		end
		// Tapped ahead of any flop; receivers synchronise it themselves
		alt_func_input = pad_in & input_en;
	end

endmodule

// [ppom_top.sv]
// Port B pin override mux with AHB-Lite register slave
//
// Contract
// - pull-up follows override value when enabled
// - otherwise pull-up only for pattern 010
// - driver enable follows direction override when enabled
// - otherwise driver enable follows direction bit
// - driven value uses value override when enabled
// - otherwise driven value is output latch
// - toggle override inverts the output latch bit
// - input enable follows override value when enabled
// - otherwise input enable from normal or sleep
// - alternate input tapped before the synchroniser
// - analog path goes straight to pad
// - overrides generated by owning peripheral logic
// - bit 7 clock pin reads zero
// - async timer without external clock detaches bit 7
// - chip oscillator pins denied as I/O
// - timer oscillator pins only with RC and async
// - every pin is pin-change source, same index
// - fixed port B alternate function assignment
// - global pull-up off disables plain pull-ups
// - writing one to pin register toggles latch
// - sleep clamp forces plain inputs low
`timescale 1ns/10ps
module ppom_top
	import ppom_pkg::*;
(
	input  wire logic              CORE_CLK,
	input  wire logic              RESET_N,
	input  wire logic              HSEL,
	input  wire logic [31:0]       HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output logic      [31:0]       HRDATA,
	output logic                   HREADYOUT,
	output logic                   HRESP,
	input  wire ppom_periph_t      PERIPH,
	input  wire logic [7:0]        TOGGLE_OVR,
	input  wire logic              SLEEP_CLAMP,
	input  wire logic [7:0]        PAD_IN,
	output logic      [7:0]        PAD_OUT,
	output logic      [7:0]        PAD_OE,
	output logic      [7:0]        PAD_PULLUP,
	output logic      [7:0]        PAD_ANALOG_SEL,
	output logic      [7:0]        ALT_FUNC_INPUT,
	output logic      [7:0]        PIN_CHANGE_SRC,
	output logic                   CHIP_OSC_ACTIVE,
	output logic                   TIMER_OSC_AMP_OUT
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0]          latch_q;
	logic [7:0]          latch_d;
	logic [7:0]          dir_q;
	logic [7:0]          dir_d;
	logic [7:0]          pcmsk_q;
	logic [7:0]          pcmsk_d;
	logic [PPOM_CTRL_W-1:0] ctrl_q;
	logic [PPOM_CTRL_W-1:0] ctrl_d;
	logic [7:0]          sync1_q;
	logic [7:0]          sync2_q;
	logic                wr_pend_q;
	logic                wr_pend_d;
	logic [PPOM_AW-1:0]  wr_addr_q;
	logic [PPOM_AW-1:0]  wr_addr_d;
	logic [31:0]         rdata_q;
	logic [31:0]         rdata_d;

	// ------------------------------------------------------------
	// Derived signals
	// ------------------------------------------------------------
	ppom_ovr_t           ovr [PPOM_PINS];
	ppom_pad_t           pad [PPOM_PINS];
	logic [7:0]          alt_in;
	logic [7:0]          analog_req;
	logic [7:0]          pin_gated;
	logic [7:0]          rd_mask;
	logic                pullup_off;
	logic                async_sel;
	logic                ext_clk_sel;
	logic                intrc;
	logic                extck;
	logic                pcie;
	logic                chip_in_use;
	logic                chip_out_use;
	logic                tmr_in_use;
	logic                tmr_out_use;
	logic                pb6_clk;
	logic                pb7_clk;
	logic                spi_slave;
	logic                spi_mst;
	logic                addr_ok;

	assign pullup_off  = ctrl_q[PPOM_CTRL_PULLUP_OFF];
	assign async_sel   = ctrl_q[PPOM_CTRL_ASYNC_SEL];
	assign ext_clk_sel = ctrl_q[PPOM_CTRL_EXT_CLK_SEL];
	assign intrc = ctrl_q[PPOM_CTRL_INTRC];
	assign extck = ctrl_q[PPOM_CTRL_EXTCK];
	assign pcie  = ctrl_q[PPOM_CTRL_PCIE];

	// ------------------------------------------------------------
	// Oscillator pin takeover
	// ------------------------------------------------------------
	always_comb
	begin
		// An external clock needs only the input pin, so bit 7 stays free then
		chip_in_use  = !intrc;
		chip_out_use = !intrc && !extck;
		tmr_in_use   = intrc && async_sel;
		tmr_out_use  = intrc && async_sel && !ext_clk_sel;
		pb6_clk      = chip_in_use || tmr_in_use;
		pb7_clk      = chip_out_use || tmr_out_use;
		spi_slave = PERIPH.spi_en && !PERIPH.spi_master;
		spi_mst   = PERIPH.spi_en && PERIPH.spi_master;
	end

	// ------------------------------------------------------------
	// Override sources, grouped per owning peripheral
	// ------------------------------------------------------------
	// Each group stands for the function owner; the register file never sets these
	always_comb
	begin
		for (int i = 0; i < PPOM_PINS; i++)
		begin
			ovr[i]                  = '0;
			ovr[i].toggle_ovr_en    = TOGGLE_OVR[i];
			// Pin change sensing keeps the input alive through sleep
			ovr[i].input_en_ovr_en  = pcmsk_q[i] && pcie;
			ovr[i].input_en_ovr_val = 1'b1;
		end
		analog_req = '0;
		// SPI owner: forced inputs keep the latch-steered pull-up
		if (spi_slave)
		begin
			ovr[5].pullup_ovr_en  = 1'b1;
			ovr[5].pullup_ovr_val = latch_q[5] && !pullup_off;
			ovr[5].dir_ovr_en     = 1'b1;
			ovr[3].pullup_ovr_en  = 1'b1;
			ovr[3].pullup_ovr_val = latch_q[3] && !pullup_off;
			ovr[3].dir_ovr_en     = 1'b1;
			ovr[2].pullup_ovr_en  = 1'b1;
			ovr[2].pullup_ovr_val = latch_q[2] && !pullup_off;
			ovr[2].dir_ovr_en     = 1'b1;
			ovr[4].value_ovr_en   = 1'b1;
			ovr[4].value_ovr_val  = PERIPH.spi_slave_out;
		end
		if (spi_mst)
		begin
			ovr[4].pullup_ovr_en  = 1'b1;
			ovr[4].pullup_ovr_val = latch_q[4] && !pullup_off;
			ovr[4].dir_ovr_en     = 1'b1;
			ovr[5].value_ovr_en   = 1'b1;
			ovr[5].value_ovr_val  = PERIPH.sck_out;
		end
		// Timer owners: the pin must already be an output to show the compare
		ovr[3].value_ovr_en  = spi_mst || PERIPH.t2_cmp_a_en;
		ovr[3].value_ovr_val = (spi_mst && PERIPH.spi_master_out)
			|| (PERIPH.t2_cmp_a_en && PERIPH.timer2_cmp_a_out);
		ovr[2].value_ovr_en  = PERIPH.t1_cmp_b_en;
		ovr[2].value_ovr_val = PERIPH.timer1_cmp_b_out;
		ovr[1].value_ovr_en  = PERIPH.t1_cmp_a_en;
		ovr[1].value_ovr_val = PERIPH.timer1_cmp_a_out;
		// Clock output owner drives bit 0 regardless of direction and latch
		if (PERIPH.clk_out_en)
		begin
			ovr[0].dir_ovr_en    = 1'b1;
			ovr[0].dir_ovr_val   = 1'b1;
			ovr[0].value_ovr_en  = 1'b1;
			ovr[0].value_ovr_val = PERIPH.divided_clk_out;
		end
		// Clock owner: oscillator pins leave the digital path entirely
		if (pb6_clk)
		begin
			ovr[6].pullup_ovr_en    = 1'b1;
			ovr[6].dir_ovr_en       = 1'b1;
			ovr[6].value_ovr_en     = 1'b1;
			ovr[6].input_en_ovr_en  = 1'b1;
			ovr[6].input_en_ovr_val = 1'b0;
			analog_req[6]           = 1'b1;
		end
		if (pb7_clk)
		begin
			ovr[7].pullup_ovr_en    = 1'b1;
			ovr[7].dir_ovr_en       = 1'b1;
			ovr[7].value_ovr_en     = 1'b1;
			ovr[7].input_en_ovr_en  = 1'b1;
			ovr[7].input_en_ovr_val = 1'b0;
			analog_req[7]           = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Pin cells
	// ------------------------------------------------------------
	for (genvar g = 0; g < PPOM_PINS; g++)
	begin : g_pin
		ppom_pin_cell u_cell
		(
			.ovr               (ovr[g]),
			.pin_direction_bit (dir_q[g]),
			.pin_out_latch_bit (latch_q[g]),
			.global_pullup_off (pullup_off),
			.sleep_clamp       (SLEEP_CLAMP),
			.analog_req        (analog_req[g]),
			.pad_in            (PAD_IN[g]),
			.pad               (pad[g]),
			.alt_func_input    (alt_in[g])
		);
		assign PAD_OUT[g]        = pad[g].drv_val;
		assign PAD_OE[g]         = pad[g].drv_en;
		assign PAD_PULLUP[g]     = pad[g].pullup_en;
		assign PAD_ANALOG_SEL[g] = pad[g].analog_sel;
		assign pin_gated[g]      = alt_in[g];
	end

	assign ALT_FUNC_INPUT    = alt_in;
	assign PIN_CHANGE_SRC    = alt_in & pcmsk_q & {8{pcie}};
	assign CHIP_OSC_ACTIVE   = chip_in_use;
	assign TIMER_OSC_AMP_OUT = tmr_out_use;

	// ------------------------------------------------------------
	// Input synchroniser for the pin register
	// ------------------------------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= pin_gated;
			sync2_q <= sync1_q;
		end
	end

	// ------------------------------------------------------------
	// AHB-Lite slave: zero wait, OKAY always
	// ------------------------------------------------------------
	assign HREADYOUT = 1'b1;
	assign HRESP     = PPOM_HRESP_OKAY;
	assign HRDATA    = rdata_q;

	always_comb
	begin
		addr_ok = HSEL && HREADY && (HTRANS == PPOM_HTRANS_NONSEQ
			|| HTRANS == PPOM_HTRANS_SEQ);
		// Clock pins hide their latch, direction and pin bits from software
		rd_mask = {~pb7_clk, ~pb6_clk, 6'h3F};
	end

	always_comb
	begin
		latch_d   = latch_q;
		dir_d     = dir_q;
		pcmsk_d   = pcmsk_q;
		ctrl_d    = ctrl_q;
		wr_pend_d = addr_ok && HWRITE;
		wr_addr_d = addr_ok ? HADDR[PPOM_AW-1:0] : wr_addr_q;
		rdata_d   = rdata_q;
		if (wr_pend_q)
		begin
			if (wr_addr_q == PPOM_OFS_LATCH)
			begin
				latch_d = HWDATA[7:0];
			end
			else if (wr_addr_q == PPOM_OFS_DIR)
			begin
				dir_d = HWDATA[7:0];
			end
			else if (wr_addr_q == PPOM_OFS_PIN)
			begin
				latch_d = latch_q ^ HWDATA[7:0];
			end
			else if (wr_addr_q == PPOM_OFS_CTRL)
			begin
				ctrl_d = HWDATA[PPOM_CTRL_W-1:0];
			end
			else if (wr_addr_q == PPOM_OFS_PCMSK)
			begin
				pcmsk_d = HWDATA[7:0];
			end
		end
		// Applied after the write so a peripheral toggle is never lost
		latch_d = latch_d ^ TOGGLE_OVR;
		if (addr_ok && !HWRITE)
		begin
			rdata_d = '0;
			if (HADDR[PPOM_AW-1:0] == PPOM_OFS_LATCH)
			begin
				rdata_d[7:0] = latch_q & rd_mask;
			end
			else if (HADDR[PPOM_AW-1:0] == PPOM_OFS_DIR)
			begin
				rdata_d[7:0] = dir_q & rd_mask;
			end
			else if (HADDR[PPOM_AW-1:0] == PPOM_OFS_PIN)
			begin
				rdata_d[7:0] = sync2_q & rd_mask;
			end
			else if (HADDR[PPOM_AW-1:0] == PPOM_OFS_CTRL)
			begin
				rdata_d[PPOM_CTRL_W-1:0] = ctrl_q;
			end
			else if (HADDR[PPOM_AW-1:0] == PPOM_OFS_PCMSK)
			begin
				rdata_d[7:0] = pcmsk_q;
			end
			else if (HADDR[PPOM_AW-1:0] == PPOM_OFS_STAT)
			begin
				rdata_d[PPOM_STAT_PB6CLK] = pb6_clk;
				rdata_d[PPOM_STAT_PB7CLK] = pb7_clk;
				rdata_d[PPOM_STAT_DRV +: 8] = PAD_OE;
			end
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
		begin
			latch_q   <= PPOM_RST_LATCH;
			dir_q     <= PPOM_RST_DIR;
			pcmsk_q   <= PPOM_RST_PCMSK;
			ctrl_q    <= PPOM_RST_CTRL;
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			rdata_q   <= '0;
		end
		else
		begin
			latch_q   <= latch_d;
			dir_q     <= dir_d;
			pcmsk_q   <= pcmsk_d;
			ctrl_q    <= ctrl_d;
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			rdata_q   <= rdata_d;
		end
	end

endmodule

// [ppom_props.sv]
// Port-level checker of the pin override mux
`timescale 1ns/10ps
module ppom_props
	import ppom_pkg::*;
(
	input wire logic         CORE_CLK,
	input wire logic         RESET_N,
	input wire logic         HSEL,
	input wire logic [1:0]   HTRANS,
	input wire logic         HREADYOUT,
	input wire logic         HRESP,
	input wire ppom_periph_t PERIPH,
	input wire logic [7:0]   TOGGLE_OVR,
	input wire logic [7:0]   PAD_IN,
	input wire logic [7:0]   PAD_OUT,
	input wire logic [7:0]   PAD_OE,
	input wire logic [7:0]   PAD_PULLUP,
	input wire logic [7:0]   PAD_ANALOG_SEL,
	input wire logic [7:0]   ALT_FUNC_INPUT,
	input wire logic [7:0]   PIN_CHANGE_SRC,
	input wire logic         CHIP_OSC_ACTIVE,
	input wire logic         TIMER_OSC_AMP_OUT
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);

	// ----
	// Toggle steps: no bus write lands on the toggle edge
	// ----
	sequence s_tog_req;
		TOGGLE_OVR[1] && PAD_OE[1] && !PERIPH.t1_cmp_a_en && !($past(HSEL) && $past(HTRANS[1]));
	endsequence
	sequence s_tog_held;
		PAD_OE[1] && !PERIPH.t1_cmp_a_en;
	endsequence

	a_bus_okay: assert property (HREADYOUT && HRESP == PPOM_HRESP_OKAY)
		else $error("bus not ready or not okay");
	a_drive_gated: assert property ((PAD_OUT & ~PAD_OE) == 8'h00)
		else $error("value driven with driver off");
	a_input_tap: assert property ((ALT_FUNC_INPUT & ~PAD_IN) == 8'h00)
		else $error("alternate input not from pad");
	a_pcint_index: assert property ((PIN_CHANGE_SRC & ~ALT_FUNC_INPUT) == 8'h00)
		else $error("pin change source on wrong index");
	a_osc_exclusive: assert property (TIMER_OSC_AMP_OUT |-> !CHIP_OSC_ACTIVE)
		else $error("timer oscillator without internal clock");
	a_tosc_detach: assert property (TIMER_OSC_AMP_OUT |-> PAD_ANALOG_SEL[7] && !PAD_OE[7]
		&& !PAD_PULLUP[7])
		else $error("bit 7 not detached");
	a_xtal_deny: assert property (CHIP_OSC_ACTIVE |-> PAD_ANALOG_SEL[6] && !PAD_OE[6]
		&& !ALT_FUNC_INPUT[6])
		else $error("bit 6 still used as port");
	a_clkout_drive: assert property (PERIPH.clk_out_en |-> PAD_OE[0]
		&& PAD_OUT[0] == PERIPH.divided_clk_out)
		else $error("divided clock not on bit 0");
	a_cmp_value: assert property (PERIPH.t1_cmp_a_en && PAD_OE[1]
		|-> PAD_OUT[1] == PERIPH.timer1_cmp_a_out)
		else $error("compare output not driven");
	a_slave_input: assert property (PERIPH.spi_en && !PERIPH.spi_master
		|-> (PAD_OE & 8'h2C) == 8'h00)
		else $error("slave pins still driven");
	a_toggle_flip: assert property (s_tog_req ##1 s_tog_held
		|-> PAD_OUT[1] != $past(PAD_OUT[1]))
		else $error("toggle did not flip latch");
endmodule

// [ppom_pad_model.sv]
// Pad side: resolves each pad from driver, external source and pull-up
`timescale 1ns/10ps
module ppom_pad_model
(
	input  wire logic       clk,
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] pad_pullup,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pad_in
);
	// A floating pad keeps changing so it never passes for a level
	logic [7:0] float_q = 8'h55;
	always_ff @(posedge clk)
		float_q <= ~float_q;
	always_comb
		for (int i = 0; i < 8; i++)
			pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i]
				: pad_pullup[i] ? 1'b1 : float_q[i];
endmodule

// [test_ppom_top.sv]
// Self-checking bench of the port pin override mux
`timescale 1ns/10ps
module test_ppom_top
	import ppom_pkg::*;
;
	logic         CORE_CLK = 1'b0;
	logic         RESET_N = 1'b0;
	logic         HSEL = 1'b0;
	logic [31:0]  HADDR = 32'h0;
	logic [1:0]   HTRANS = 2'h0;
	logic         HWRITE = 1'b0;
	logic [2:0]   HSIZE = 3'h2;
	logic [31:0]  HWDATA = 32'h0;
	logic         HREADY;
	logic [31:0]  HRDATA;
	logic         HREADYOUT, HRESP, CHIP_OSC_ACTIVE, TIMER_OSC_AMP_OUT;
	ppom_periph_t PERIPH = '0;
	logic [7:0]   TOGGLE_OVR = 8'h00;
	logic         SLEEP_CLAMP = 1'b0;
	logic [7:0]   PAD_IN, PAD_OUT, PAD_OE, PAD_PULLUP, PAD_ANALOG_SEL;
	logic [7:0]   ALT_FUNC_INPUT, PIN_CHANGE_SRC;
	logic [7:0]   ext_en = 8'h00, ext_val = 8'h00;
	logic [31:0]  exp_q[$];
	logic [31:0]  seen, rd;
	string        what;
	int           mismatches = 0, n_tests = 0;
	event         got_reg, got_pad;
	localparam int S_OE = 0, S_OUT = 1, S_PU = 2, S_AN = 3, S_AI = 4, S_PC = 5, S_OSC = 6;
	string        names[7] = '{"oe", "out", "pullup", "analog", "altin", "pcint", "osc"};

	assign HREADY = HREADYOUT;
	always #4 CORE_CLK = ~CORE_CLK;
	ppom_top dut (.*);
	ppom_pad_model pads (
		.clk        (CORE_CLK),
		.pad_out    (PAD_OUT),
		.pad_oe     (PAD_OE),
		.pad_pullup (PAD_PULLUP),
		.ext_en     (ext_en),
		.ext_val    (ext_val),
		.pad_in     (PAD_IN)
	);

	// ----
	// Watcher and reporting
	// ----
	always @(got_reg) compare_reg(exp_q.pop_front(), seen);
	always @(got_pad) compare_pad(exp_q.pop_front(), seen);

	task automatic compare_reg(input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic compare_pad(input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s[7:0] !== e[7:0])
		begin
			mismatches++;
			$display("unexpected pad %s expected %h seen %h", what, e[7:0], s[7:0]);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----
	// Bus and pad drivers
	// ----
	task automatic wait_ready();
		int k;
		k = 0;
		@(posedge CORE_CLK);
		while (HREADYOUT !== 1'b1)
		begin
			k++;
			if (k > 20)
			begin
				mismatches++;
				complete_run();
			end
			@(posedge CORE_CLK);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		HSEL <= 1'b1;
		HTRANS <= PPOM_HTRANS_NONSEQ;
		HADDR <= {24'h000000, a};
		HWRITE <= w;
		wait_ready();
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		wait_ready();
		rd = HRDATA;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
		seen = rd;
		what = $sformatf("register %h", a);
		->got_reg;
	endtask

	function automatic logic [7:0] obs(input int s);
		case (s)
			S_OE:    return PAD_OE;
			S_OUT:   return PAD_OUT;
			S_PU:    return PAD_PULLUP;
			S_AN:    return PAD_ANALOG_SEL;
			S_AI:    return ALT_FUNC_INPUT;
			S_PC:    return PIN_CHANGE_SRC;
			default: return {6'h00, TIMER_OSC_AMP_OUT, CHIP_OSC_ACTIVE};
		endcase
	endfunction

	task automatic expect_pad(input int s, input logic [7:0] m, input logic [7:0] e);
		@(negedge CORE_CLK);
		exp_q.push_back({24'h000000, e & m});
		seen = {24'h000000, obs(s) & m};
		what = names[s];
		->got_pad;
	endtask

	// ----
	// Scenarios
	// ----
	initial
	begin
		logic [7:0] r, v;
		r = $urandom(32'hA057);
		repeat (5) @(posedge CORE_CLK);
		RESET_N <= 1'b1;
		chk_reg(PPOM_OFS_CTRL, {26'h0, PPOM_RST_CTRL});
		chk_reg(PPOM_OFS_LATCH, 32'h0);
		chk_reg(8'h20, 32'h0);
		expect_pad(S_OE, 8'hFF, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			wr(PPOM_OFS_CTRL, {28'h0, 4'h8 | i[0]});
			wr(PPOM_OFS_DIR, {24'h0, {8{i[2]}}});
			wr(PPOM_OFS_LATCH, {24'h0, {8{i[1]}}});
			expect_pad(S_PU, 8'hFF, (i == 2) ? 8'hFF : 8'h00);
			expect_pad(S_OE, 8'hFF, {8{i[2]}});
			expect_pad(S_OUT, 8'hFF, {8{i[2] & i[1]}});
		end
		r = $urandom();
		v = $urandom();
		wr(PPOM_OFS_LATCH, {24'h0, r});
		wr(PPOM_OFS_PIN, {24'h0, v});
		v = ~(r ^ v);
		chk_reg(PPOM_OFS_LATCH, {24'h0, ~v});
		@(posedge CORE_CLK);
		TOGGLE_OVR <= 8'hFF;
		@(posedge CORE_CLK);
		TOGGLE_OVR <= 8'h00;
		chk_reg(PPOM_OFS_LATCH, {24'h0, v});
		PERIPH.t1_cmp_a_en <= 1'b1;
		PERIPH.timer1_cmp_a_out <= ~v[1];
		PERIPH.clk_out_en <= 1'b1;
		PERIPH.divided_clk_out <= 1'b1;
		PERIPH.spi_en <= 1'b1;
		wr(PPOM_OFS_DIR, 32'hFE);
		wr(PPOM_OFS_CTRL, 32'h08);
		expect_pad(S_OUT, 8'h03, {6'h00, ~v[1], 1'b1});
		expect_pad(S_OE, 8'h2D, 8'h01);
		expect_pad(S_PU, 8'h2C, v);
		@(posedge CORE_CLK);
		PERIPH.spi_master <= 1'b1;
		PERIPH.sck_out <= 1'b0;
		PERIPH.spi_master_out <= 1'b1;
		expect_pad(S_OE, 8'h30, 8'h20);
		expect_pad(S_OUT, 8'h28, 8'h08);
		expect_pad(S_PU, 8'h10, v);
		@(posedge CORE_CLK);
		PERIPH <= '0;
		r = $urandom();
		ext_val <= r;
		ext_en <= 8'hFF;
		wr(PPOM_OFS_DIR, 32'h0);
		wr(PPOM_OFS_PCMSK, 32'hFF);
		wr(PPOM_OFS_CTRL, 32'h28);
		expect_pad(S_PC, 8'hFF, r);
		chk_reg(PPOM_OFS_PIN, {24'h0, r});
		SLEEP_CLAMP <= 1'b1;
		expect_pad(S_AI, 8'hFF, r);
		wr(PPOM_OFS_PCMSK, 32'h0F);
		expect_pad(S_AI, 8'hFF, r & 8'h0F);
		@(posedge CORE_CLK);
		SLEEP_CLAMP <= 1'b0;
		expect_pad(S_AI, 8'hFF, r);
		expect_pad(S_PC, 8'hFF, r & 8'h0F);
		wr(PPOM_OFS_LATCH, 32'hFF);
		wr(PPOM_OFS_CTRL, 32'h0A);
		expect_pad(S_OSC, 8'h03, 8'h02);
		expect_pad(S_AN, 8'hFF, 8'hC0);
		chk_reg(PPOM_OFS_LATCH, 32'h3F);
		chk_reg(PPOM_OFS_STAT, 32'h3);
		wr(PPOM_OFS_CTRL, 32'h0E);
		chk_reg(PPOM_OFS_LATCH, 32'hBF);
		wr(PPOM_OFS_CTRL, 32'h00);
		expect_pad(S_OSC, 8'h03, 8'h01);
		chk_reg(PPOM_OFS_LATCH, 32'h3F);
		RESET_N <= 1'b0;
		@(posedge CORE_CLK);
		RESET_N <= 1'b1;
		chk_reg(PPOM_OFS_CTRL, {26'h0, PPOM_RST_CTRL});
		chk_reg(PPOM_OFS_LATCH, 32'h0);
		// Let the watcher take the last note before the verdict
		@(negedge CORE_CLK);
		complete_run();
	end
endmodule

bind ppom_top ppom_props u_props (.*);
